// File: fan_lut_pkg.sv
package fan_lut_pkg;
	localparam logic [7:0] ADDR_LIMIT8 = 8'h5E;
	localparam logic [7:0] ADDR_DUTY8 = 8'h5F;
	localparam logic [7:0] ADDR_LIMIT9 = 8'h60;
	localparam logic [7:0] ADDR_DUTY9 = 8'h61;
	localparam logic [7:0] LIMIT_RESET = 8'h7F;
	localparam logic [7:0] DUTY_RESET = 8'h3F;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam int HALF_BIT = 7;
	localparam int EXT_LO = 6;
	localparam int INT_HI = 6;
	localparam int BASE_HI = 5;
	localparam int TEMP_MSB = 8;
	localparam logic [5:0] BASE_MASK = 6'h3F;
	localparam logic [1:0] EXT_ZERO = 2'h0;

	// register port carrier
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// mode and context inputs
	typedef struct packed {
		logic temp_high_res;
		logic duty_high_res;
		logic pwm_22k5;
		logic write_enable;
		logic [7:0] limit_offset;
		logic [8:0] remote_temp;
	} lut_ctrl_t;
endpackage : fan_lut_pkg

// File: fan_lut_entries_eight_nine.sv
// How it works
// - low temp resolution forces limit bit7 zero
// - high resolution limit uses all bits, half degrees
// - low resolution limit is seven bits, degrees
// - exceeding entry 8 limit selects 0x5F duty
// - compare nine bits high, eight bits low
// - limits are always non-negative
// - offset register value added to limit
// - low duty resolution forces bits 7:6 zero
// - high duty resolution uses full eight bits
// - extended duty bits only at 22.5 kHz
// - limits reset to 0x7F
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module fan_lut_entries_eight_nine (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire fan_lut_pkg::reg_req_t req_in,
	input wire fan_lut_pkg::lut_ctrl_t ctrl_in,
	output logic [7:0] rdata_out,
	output logic [7:0] duty_out,
	output logic duty_valid_out
);
	import fan_lut_pkg::*;

	////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] limit8_q;
	logic [7:0] duty8_q;
	logic [7:0] limit9_q;
	logic [7:0] duty9_q;
	logic wr_ok;
	logic ext_ok;

	assign wr_ok = req_in.wr && ctrl_in.write_enable;
	assign ext_ok = ctrl_in.duty_high_res && ctrl_in.pwm_22k5;

	function automatic logic [7:0] store_limit(input logic [7:0] v, input logic hr);
		store_limit = hr ? v : {1'b0, v[INT_HI:0]};
	endfunction : store_limit

	function automatic logic [7:0] store_duty(input logic [7:0] v, input logic hr);
		store_duty = hr ? v : {EXT_ZERO, v[BASE_HI:0]};
	endfunction : store_duty

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			limit8_q <= LIMIT_RESET;
		end else if (wr_ok && req_in.addr == ADDR_LIMIT8) begin
			limit8_q <= store_limit(req_in.wdata, ctrl_in.temp_high_res);
		end else if (!ctrl_in.temp_high_res) begin
			limit8_q[HALF_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			limit9_q <= LIMIT_RESET;
		end else if (wr_ok && req_in.addr == ADDR_LIMIT9) begin
			limit9_q <= store_limit(req_in.wdata, ctrl_in.temp_high_res);
		end else if (!ctrl_in.temp_high_res) begin
			limit9_q[HALF_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			duty8_q <= DUTY_RESET;
		end else if (wr_ok && req_in.addr == ADDR_DUTY8) begin
			duty8_q <= store_duty(req_in.wdata, ctrl_in.duty_high_res);
		end else if (!ctrl_in.duty_high_res) begin
			duty8_q[7:EXT_LO] <= EXT_ZERO;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			duty9_q <= DUTY_RESET;
		end else if (wr_ok && req_in.addr == ADDR_DUTY9) begin
			duty9_q <= store_duty(req_in.wdata, ctrl_in.duty_high_res);
		end else if (!ctrl_in.duty_high_res) begin
			duty9_q[7:EXT_LO] <= EXT_ZERO;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read port, always allowed
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_out <= READ_UNMAPPED;
		end else if (req_in.rd) begin
			unique case (req_in.addr)
				ADDR_LIMIT8: rdata_out <= limit8_q;
				ADDR_DUTY8: rdata_out <= duty8_q;
				ADDR_LIMIT9: rdata_out <= limit9_q;
				ADDR_DUTY9: rdata_out <= duty9_q;
				default: rdata_out <= READ_UNMAPPED;
			endcase
		end else begin
			rdata_out <= READ_UNMAPPED;
		end
	end

	////////////////////////////////////////////////////////////////////
	// comparison, all in half-degree units, 10 bits to hold offset sums
	logic [9:0] temp_h;
	logic [9:0] lim8_h;
	logic [9:0] lim9_h;
	logic [9:0] off_h;
	logic exceed8;
	logic exceed9;
	logic [7:0] pwm8;
	logic [7:0] pwm9;

	always_comb begin
		if (ctrl_in.temp_high_res) begin
			temp_h = {1'b0, ctrl_in.remote_temp};
			// bits 6:0 whole degrees, bit 7 the half degree
			lim8_h = {2'b00, limit8_q[INT_HI:0], limit8_q[HALF_BIT]};
			lim9_h = {2'b00, limit9_q[INT_HI:0], limit9_q[HALF_BIT]};
		end else begin
			// half-degree bit of the reading dropped, whole degrees only
			temp_h = {1'b0, ctrl_in.remote_temp[TEMP_MSB:1], 1'b0};
			lim8_h = {2'b00, limit8_q[INT_HI:0], 1'b0};
			lim9_h = {2'b00, limit9_q[INT_HI:0], 1'b0};
		end
	end

	// offset counts whole degrees in both modes, so it enters doubled
	assign off_h = {1'b0, ctrl_in.limit_offset, 1'b0};

	assign exceed8 = temp_h > (lim8_h + off_h);
	assign exceed9 = temp_h > (lim9_h + off_h);

	assign pwm8 = ext_ok ? duty8_q : {EXT_ZERO, duty8_q[BASE_HI:0] & BASE_MASK};
	assign pwm9 = ext_ok ? duty9_q : {EXT_ZERO, duty9_q[BASE_HI:0] & BASE_MASK};

	// higher entry wins when both exceeded
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			duty_out <= '0;
			duty_valid_out <= 1'b0;
		end else if (exceed9) begin
			duty_out <= pwm9;
			duty_valid_out <= 1'b1;
		end else if (exceed8) begin
			duty_out <= pwm8;
			duty_valid_out <= 1'b1;
		end else begin
			duty_out <= '0;
			duty_valid_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	// a refused write while both modes are high, so no clearing is due either
	sequence s_blocked_write;
		req_in.wr && !ctrl_in.write_enable && ctrl_in.temp_high_res && ctrl_in.duty_high_res;
	endsequence

	sequence s_regs_held;
		$stable(limit8_q) && $stable(duty8_q) && $stable(limit9_q) && $stable(duty9_q);
	endsequence

	a_write_blocked: assert property (@(posedge clk_in) disable iff (rst_in)
		s_blocked_write |=> s_regs_held)
		else $error("write landed while disabled");

	a_limit8_write: assert property (@(posedge clk_in) disable iff (rst_in)
		(wr_ok && req_in.addr == ADDR_LIMIT8 && ctrl_in.temp_high_res)
		|=> limit8_q == $past(req_in.wdata))
		else $error("entry 8 limit write lost");

	a_limit9_write: assert property (@(posedge clk_in) disable iff (rst_in)
		(wr_ok && req_in.addr == ADDR_LIMIT9 && ctrl_in.temp_high_res)
		|=> limit9_q == $past(req_in.wdata))
		else $error("entry 9 limit write lost");

	a_duty8_write: assert property (@(posedge clk_in) disable iff (rst_in)
		(wr_ok && req_in.addr == ADDR_DUTY8 && ctrl_in.duty_high_res)
		|=> duty8_q == $past(req_in.wdata))
		else $error("entry 8 duty write lost");

	a_duty9_write: assert property (@(posedge clk_in) disable iff (rst_in)
		(wr_ok && req_in.addr == ADDR_DUTY9 && ctrl_in.duty_high_res)
		|=> duty9_q == $past(req_in.wdata))
		else $error("entry 9 duty write lost");

	a_limit_top_low: assert property (@(posedge clk_in) disable iff (rst_in)
		!ctrl_in.temp_high_res |=> !limit8_q[HALF_BIT] && !limit9_q[HALF_BIT])
		else $error("limit top bit set in low resolution");

	a_duty_ext_low: assert property (@(posedge clk_in) disable iff (rst_in)
		!ctrl_in.duty_high_res
		|=> duty8_q[7:EXT_LO] == EXT_ZERO && duty9_q[7:EXT_LO] == EXT_ZERO)
		else $error("duty extended bits set in low resolution");

	// extended duty only at 22.5 kHz
	a_ext_gate: assert property (@(posedge clk_in) disable iff (rst_in)
		!ctrl_in.pwm_22k5 |=> duty_out[7:EXT_LO] == EXT_ZERO)
		else $error("extended duty used off 22.5 kHz");

	// no extended duty in low resolution
	a_ext_low_res: assert property (@(posedge clk_in) disable iff (rst_in)
		!ctrl_in.duty_high_res |=> duty_out[7:EXT_LO] == EXT_ZERO)
		else $error("extended duty used in low resolution");

	a_entry8_sel: assert property (@(posedge clk_in) disable iff (rst_in)
		(exceed8 && !exceed9) |=> duty_valid_out && duty_out == $past(pwm8))
		else $error("entry 8 duty not driven");

	a_entry9_sel: assert property (@(posedge clk_in) disable iff (rst_in)
		exceed9 |=> duty_valid_out && duty_out == $past(pwm9))
		else $error("entry 9 duty not driven");

	a_no_exceed: assert property (@(posedge clk_in) disable iff (rst_in)
		(!exceed8 && !exceed9) |=> !duty_valid_out)
		else $error("duty driven below limits");

	a_idle_zero: assert property (@(posedge clk_in) disable iff (rst_in)
		!duty_valid_out |-> duty_out == '0)
		else $error("duty output not zero while idle");

	// a zero reading exceeds no limit
	a_zero_temp: assert property (@(posedge clk_in) disable iff (rst_in)
		ctrl_in.remote_temp == '0 |-> !exceed8 && !exceed9)
		else $error("zero reading exceeded a limit");

	a_whole_degree: assert property (@(posedge clk_in) disable iff (rst_in)
		!ctrl_in.temp_high_res |-> !temp_h[0])
		else $error("half degree used in low resolution");

	// offset is a floor for every limit
	a_offset_floor: assert property (@(posedge clk_in) disable iff (rst_in)
		(exceed8 || exceed9) |-> temp_h > off_h)
		else $error("limit exceeded below the offset");

	a_read_limit8: assert property (@(posedge clk_in) disable iff (rst_in)
		(req_in.rd && req_in.addr == ADDR_LIMIT8) |=> rdata_out == $past(limit8_q))
		else $error("entry 8 limit read wrong");

	a_read_duty8: assert property (@(posedge clk_in) disable iff (rst_in)
		(req_in.rd && req_in.addr == ADDR_DUTY8) |=> rdata_out == $past(duty8_q))
		else $error("entry 8 duty read wrong");

	a_read_limit9: assert property (@(posedge clk_in) disable iff (rst_in)
		(req_in.rd && req_in.addr == ADDR_LIMIT9) |=> rdata_out == $past(limit9_q))
		else $error("entry 9 limit read wrong");

	a_read_duty9: assert property (@(posedge clk_in) disable iff (rst_in)
		(req_in.rd && req_in.addr == ADDR_DUTY9) |=> rdata_out == $past(duty9_q))
		else $error("entry 9 duty read wrong");

	// read data stands one cycle only
	a_read_idle: assert property (@(posedge clk_in) disable iff (rst_in)
		!req_in.rd |=> rdata_out == READ_UNMAPPED)
		else $error("read data outside its cycle");

	// limits come out of reset at their reset value
	a_limit_reset: assert property (@(posedge clk_in)
		(!rst_in && $past(rst_in)) |-> limit8_q == LIMIT_RESET && limit9_q == LIMIT_RESET)
		else $error("limit reset value wrong");
endmodule : fan_lut_entries_eight_nine
`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import fan_lut_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	reg_req_t req = '0;
	lut_ctrl_t ctrl = '0;
	logic [7:0] rdata_out;
	logic [7:0] duty_out;
	logic duty_valid_out;
	int n_errors = 0;
	int num_checks = 0;
	fan_lut_entries_eight_nine DUT (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.req_in(req),
		.ctrl_in(ctrl),
		.rdata_out(rdata_out),
		.duty_out(duty_out),
		.duty_valid_out(duty_valid_out)
	);
	always #5 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		req.wr <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		req.rd <= 1'b0;
		#1 chk(rdata_out, exp);
	endtask : rd
	// two edges let the registered outputs follow the new inputs
	task automatic temp(input logic [8:0] t, input logic v, input logic [7:0] d);
		@(posedge clk_in);
		ctrl.remote_temp <= t;
		repeat (2) @(posedge clk_in);
		#1 chk({7'h00, duty_valid_out}, {7'h00, v});
		chk(duty_out, d);
	endtask : temp
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		n_errors++;
		close_out();
	end
	initial begin
		ctrl.temp_high_res <= 1'b1;
		ctrl.duty_high_res <= 1'b1;
		ctrl.pwm_22k5 <= 1'b1;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(ADDR_LIMIT8, 8'h7F);
		rd(ADDR_DUTY8, 8'h3F);
		rd(ADDR_LIMIT9, 8'h7F);
		rd(ADDR_DUTY9, 8'h3F);
		rd(8'h62, READ_UNMAPPED);
		wr(ADDR_LIMIT8, 8'h10);
		rd(ADDR_LIMIT8, 8'h7F);
		@(posedge clk_in);
		ctrl.write_enable <= 1'b1;
		wr(ADDR_LIMIT8, 8'h81);
		wr(ADDR_DUTY8, 8'hC5);
		wr(ADDR_LIMIT9, 8'hA0);
		wr(ADDR_DUTY9, 8'hFF);
		wr(8'h62, 8'h55);
		rd(ADDR_LIMIT8, 8'h81);
		rd(ADDR_DUTY8, 8'hC5);
		rd(ADDR_LIMIT9, 8'hA0);
		rd(ADDR_DUTY9, 8'hFF);
		rd(8'h62, READ_UNMAPPED);
		temp(9'h003, 1'b0, 8'h00);
		temp(9'h004, 1'b1, 8'hC5);
		temp(9'h042, 1'b1, 8'hFF);
		@(posedge clk_in);
		ctrl.pwm_22k5 <= 1'b0;
		temp(9'h042, 1'b1, 8'h3F);
		@(posedge clk_in);
		ctrl.pwm_22k5 <= 1'b1;
		ctrl.limit_offset <= 8'h01;
		temp(9'h005, 1'b0, 8'h00);
		temp(9'h006, 1'b1, 8'hC5);
		@(posedge clk_in);
		ctrl.limit_offset <= 8'h00;
		ctrl.temp_high_res <= 1'b0;
		rd(ADDR_LIMIT8, 8'h01);
		rd(ADDR_LIMIT9, 8'h20);
		temp(9'h003, 1'b0, 8'h00);
		temp(9'h004, 1'b1, 8'hC5);
		temp(9'h042, 1'b1, 8'hFF);
		@(posedge clk_in);
		ctrl.duty_high_res <= 1'b0;
		rd(ADDR_DUTY8, 8'h05);
		rd(ADDR_DUTY9, 8'h3F);
		wr(ADDR_DUTY8, 8'hEA);
		rd(ADDR_DUTY8, 8'h2A);
		temp(9'h004, 1'b1, 8'h2A);
		close_out();
	end
endmodule : tb
`default_nettype wire
